/* src/fsi_baud_detect.sv */
// Automatic line rate detection from the shortest edge interval
`timescale 1ns/100ps
module fsi_baud_detect
  import fsi_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT = IDLE_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       rx_pin,
  output logic [3:0]      rate_idx,
  output logic            rate_locked
);

  logic [2:0]  rx_sync_reg;
  logic        rx_level_reg;
  logic [31:0] gap_reg;
  logic [15:0] min_reg;
  logic [7:0]  edges_reg;
  logic        rx_edge;

  // Shortest gap between edges is one bit time; pick the fastest rate whose bit time times 3/2 still exceeds the gap
  function automatic logic [3:0] classify(input logic [15:0] gap);
    logic [3:0] idx;
    idx = 4'h0;
    // Thresholds fall as rates rise, so the last rate that still fits is the fastest
    for (int i = 0; i < RATE_COUNT; i++)
    begin
      if (32'(gap) < (CLK_HZ / RATE_BPS[i]) * 3 / 2)
        idx = 4'(i);
    end
    return idx;
  endfunction : classify

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_sync_reg <= 3'h7;
    else
      rx_sync_reg <= {rx_sync_reg[1:0], rx_pin};
  end

  // A level counts only once two stages agree, so a one-cycle glitch is dropped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rx_level_reg <= 1'b1;
    else if (rx_sync_reg[1] == rx_sync_reg[2])
      rx_level_reg <= rx_sync_reg[2];
  end

  assign rx_edge = (rx_sync_reg[1] == rx_sync_reg[2]) && (rx_sync_reg[2] != rx_level_reg);

  // ----------------------------------------------------------------
  // Interval measurement; a quiet line restarts the hunt
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_reg   <= 32'h0;
      min_reg   <= INTERVAL_MAX;
      edges_reg <= 8'h0;
    end
    else if (rx_edge)
    begin
      gap_reg <= 32'h1;
      if (gap_reg != 32'h0 && gap_reg < 32'(min_reg))
        min_reg <= gap_reg[15:0];
      if (edges_reg != LOCK_EDGES)
        edges_reg <= edges_reg + 8'h1;
    end
    else if (gap_reg >= IDLE_LIMIT)
    begin
      // The idle stretch itself must not be taken as a bit time
      gap_reg   <= 32'h0;
      min_reg   <= INTERVAL_MAX;
      edges_reg <= 8'h0;
    end
    else if (gap_reg != 32'h0)
      gap_reg <= gap_reg + 32'h1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rate_idx    <= 4'h0;
      rate_locked <= 1'b0;
    end
    else
    begin
      rate_idx    <= classify(min_reg);
      rate_locked <= edges_reg == LOCK_EDGES;
    end
  end

  lock_edges_a: assert property (@(posedge clk) disable iff (!reset_n)
    (edges_reg != LOCK_EDGES) |=> !rate_locked)
    else $error("rate lock without enough edges");

endmodule : fsi_baud_detect

/* src/fsi_pkg.sv */
// Constants and types for the fieldbus status indicator block
package fsi_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_NS       = 100_000_000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned IDLE_NS       = 5_000_000;
  localparam int unsigned IDLE_CYCLES   = IDLE_NS / CLK_PERIOD_NS;

  // Pattern phases count 100 ms ticks; one pattern period is 2 s
  localparam logic [4:0] PHASE_LAST       = 5'h13;
  localparam logic [4:0] COUNT_DARK_TICKS = 5'h03;
  localparam logic [4:0] FLASH_HALF_TICKS = 5'h05;
  localparam logic [4:0] FLASH_ON2_START  = 5'h0a;
  localparam logic [4:0] FLASH_ON2_END    = 5'h0f;
  localparam logic [4:0] DBL_ON1_END      = 5'h02;
  localparam logic [4:0] DBL_ON2_START    = 5'h04;
  localparam logic [4:0] DBL_ON2_END      = 5'h06;

  // ----------------------------------------------------------------
  // Measurement and addressing
  // ----------------------------------------------------------------
  localparam int unsigned READ_W         = 24;
  localparam int unsigned ZERO_FRAC_BITS = 4;
  localparam logic signed [23:0] ZERO_BAND = 24'sh000004;
  localparam logic [6:0] ADDR_MIN   = 7'h01;
  localparam logic [6:0] ADDR_MAX   = 7'h7e;
  localparam logic [6:0] ADDR_RESET = 7'h01;

  // Cyclic layout the master must configure; slot 0 is unused
  localparam int unsigned SLOT_COUNT = 3;
  localparam int unsigned SLOT_WORDS = 2;

  // ----------------------------------------------------------------
  // Line rates, slowest first
  // ----------------------------------------------------------------
  localparam int unsigned RATE_COUNT = 10;
  localparam int unsigned RATE_BPS [RATE_COUNT] = '{
    9_600, 19_200, 45_450, 93_750, 187_500,
    500_000, 1_500_000, 3_000_000, 6_000_000, 12_000_000};
  localparam logic [7:0]  LOCK_EDGES = 8'h10;
  localparam logic [15:0] INTERVAL_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // Indication states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MS_OFF   = 4'b0001,
    MS_GREEN = 4'b0010,
    MS_DIAG  = 4'b0100,
    MS_EXCPT = 4'b1000
  } fsi_ms_type;

  typedef enum logic [3:0] {
    NS_OFF    = 4'b0001,
    NS_RUN    = 4'b0010,
    NS_CLEAR  = 4'b0100,
    NS_CFGERR = 4'b1000
  } fsi_ns_type;

endpackage : fsi_pkg

/* src/fsi_status_led.sv */
// Front-panel LED drive, station address and line rate for the slave
`timescale 1ns/100ps
module fsi_status_led
  import fsi_pkg::*;
#(
  parameter int unsigned TICK_LEN  = TICK_CYCLES,
  parameter int unsigned IDLE_LEN  = IDLE_CYCLES
)
(
  input  wire logic                CORE_CLK,
  input  wire logic                RESET_N,
  input  wire logic                COUNT_MODE,
  input  wire logic                STABLE_IN,
  input  wire logic signed [23:0]  READING,
  input  wire logic                ADC_ERROR,
  input  wire logic                DSP_ERROR,
  input  wire logic [1:0]          ERROR_TYPE,
  input  wire logic                MODULE_INIT_DONE,
  input  wire logic                DIAG_PENDING,
  input  wire logic                EXCEPTION_ERROR,
  input  wire logic                BUS_ONLINE,
  input  wire logic                DATA_EXCHANGE,
  input  wire logic                BUS_CFG_ERROR,
  input  wire logic                ADDR_WRITE,
  input  wire logic [6:0]          ADDR_VALUE,
  input  wire logic                CFG_RESET,
  input  wire logic                BUS_RX,
  output logic                     STABLE_LED,
  output logic                     ZERO_LED,
  output logic                     ERROR_LED,
  output logic                     MODULE_STATE_LED_GREEN,
  output logic                     MODULE_STATE_LED_RED,
  output logic                     NETWORK_OPERATION_LED_GREEN,
  output logic                     NETWORK_OPERATION_LED_RED,
  output logic [6:0]               STATION_ADDR,
  output logic [3:0]               LINE_RATE,
  output logic                     LINE_RATE_LOCKED
);

  logic [31:0]      tick_cnt_reg;
  logic [4:0]       phase_reg;
  logic             flash_on;
  logic             dbl_on;
  logic             count_dark;
  logic             in_zero_band;
  logic             err_active;
  fsi_ms_type       ms_next;
  fsi_ns_type       ns_next;
  logic [3:0]       rate_idx;
  logic             rate_locked;

  // ----------------------------------------------------------------
  // Pattern time base: 100 ms ticks, 20 phases per 2 s
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      tick_cnt_reg <= 32'h0;
    else if (tick_cnt_reg >= TICK_LEN - 1)
      tick_cnt_reg <= 32'h0;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      phase_reg <= 5'h0;
    else if (tick_cnt_reg >= TICK_LEN - 1)
      phase_reg <= (phase_reg == PHASE_LAST) ? 5'h0 : phase_reg + 5'h1;
  end

  // Shared clock keeps all flashing LEDs in step with each other
  assign flash_on   = (phase_reg < FLASH_HALF_TICKS) ||
                      (phase_reg >= FLASH_ON2_START && phase_reg < FLASH_ON2_END);
  // Two 200 ms blinks then a 1.4 s dark pause
  assign dbl_on     = (phase_reg < DBL_ON1_END) ||
                      (phase_reg >= DBL_ON2_START && phase_reg < DBL_ON2_END);
  assign count_dark = phase_reg < COUNT_DARK_TICKS;

  // ----------------------------------------------------------------
  // Measurement LEDs
  // ----------------------------------------------------------------
  // Reading carries four fraction bits per display division
  assign in_zero_band = (READING > -ZERO_BAND) && (READING < ZERO_BAND);
  assign err_active   = ADC_ERROR || DSP_ERROR;

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      STABLE_LED <= 1'b0;
      ZERO_LED   <= 1'b0;
      ERROR_LED  <= 1'b0;
    end
    else if (err_active)
    begin
      // Error type code takes over the two other LEDs
      STABLE_LED <= ERROR_TYPE[0];
      ZERO_LED   <= ERROR_TYPE[1];
      ERROR_LED  <= 1'b1;
    end
    else if (COUNT_MODE)
    begin
      STABLE_LED <= !count_dark;
      ZERO_LED   <= 1'b0;
      ERROR_LED  <= 1'b0;
    end
    else
    begin
      STABLE_LED <= STABLE_IN;
      ZERO_LED   <= in_zero_band;
      ERROR_LED  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Module state LED
  // ----------------------------------------------------------------
  always_comb
  begin
    if (EXCEPTION_ERROR)
      ms_next = MS_EXCPT;
    else if (!MODULE_INIT_DONE)
      ms_next = MS_OFF;
    else if (DIAG_PENDING)
      ms_next = MS_DIAG;
    else
      ms_next = MS_GREEN;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      MODULE_STATE_LED_GREEN <= 1'b0;
      MODULE_STATE_LED_RED   <= 1'b0;
    end
    else
    begin
      unique case (ms_next)
        MS_OFF:
        begin
          MODULE_STATE_LED_GREEN <= 1'b0;
          MODULE_STATE_LED_RED   <= 1'b0;
        end
        MS_GREEN:
        begin
          MODULE_STATE_LED_GREEN <= 1'b1;
          MODULE_STATE_LED_RED   <= 1'b0;
        end
        MS_DIAG:
        begin
          MODULE_STATE_LED_GREEN <= flash_on;
          MODULE_STATE_LED_RED   <= 1'b0;
        end
        MS_EXCPT:
        begin
          MODULE_STATE_LED_GREEN <= 1'b0;
          MODULE_STATE_LED_RED   <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Network operation LED
  // ----------------------------------------------------------------
  always_comb
  begin
    if (BUS_CFG_ERROR)
      ns_next = NS_CFGERR;
    else if (!BUS_ONLINE)
      ns_next = NS_OFF;
    else if (DATA_EXCHANGE)
      ns_next = NS_RUN;
    else
      ns_next = NS_CLEAR;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      NETWORK_OPERATION_LED_GREEN <= 1'b0;
      NETWORK_OPERATION_LED_RED   <= 1'b0;
    end
    else
    begin
      unique case (ns_next)
        NS_OFF:
        begin
          NETWORK_OPERATION_LED_GREEN <= 1'b0;
          NETWORK_OPERATION_LED_RED   <= 1'b0;
        end
        NS_RUN:
        begin
          NETWORK_OPERATION_LED_GREEN <= 1'b1;
          NETWORK_OPERATION_LED_RED   <= 1'b0;
        end
        NS_CLEAR:
        begin
          NETWORK_OPERATION_LED_GREEN <= flash_on;
          NETWORK_OPERATION_LED_RED   <= 1'b0;
        end
        NS_CFGERR:
        begin
          NETWORK_OPERATION_LED_GREEN <= 1'b0;
          NETWORK_OPERATION_LED_RED   <= dbl_on;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Station address
  // ----------------------------------------------------------------
  // Out-of-range writes are dropped so the address stays usable
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      STATION_ADDR <= ADDR_RESET;
    else if (CFG_RESET)
      STATION_ADDR <= ADDR_RESET;
    else if (ADDR_WRITE && ADDR_VALUE >= ADDR_MIN && ADDR_VALUE <= ADDR_MAX)
      STATION_ADDR <= ADDR_VALUE;
  end

  // ----------------------------------------------------------------
  // Line rate
  // ----------------------------------------------------------------
  fsi_baud_detect #(
    .IDLE_LIMIT  (IDLE_LEN)
  ) u_baud (
    .clk         (CORE_CLK),
    .reset_n     (RESET_N),
    .rx_pin      (BUS_RX),
    .rate_idx    (rate_idx),
    .rate_locked (rate_locked)
  );

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      LINE_RATE        <= 4'h0;
      LINE_RATE_LOCKED <= 1'b0;
    end
    else
    begin
      LINE_RATE        <= rate_idx;
      LINE_RATE_LOCKED <= rate_locked;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  count_dark_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (COUNT_MODE && !err_active && phase_reg < 5'h03) |=> !STABLE_LED)
    else $error("stable LED lit in count dark phase");
  count_lit_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (COUNT_MODE && !err_active && phase_reg >= 5'h03) |=> STABLE_LED)
    else $error("stable LED dark outside count dark phase");
  zero_band_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (!COUNT_MODE && !err_active) |=> (ZERO_LED == ($past(READING) > -24'sd4
                                      && $past(READING) < 24'sd4)))
    else $error("zero LED disagrees with reading band");
  zero_count_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (COUNT_MODE && !err_active) |=> !ZERO_LED)
    else $error("zero LED lit in count mode");
  error_code_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (ADC_ERROR || DSP_ERROR) |=> (ERROR_LED && {ZERO_LED, STABLE_LED} == $past(ERROR_TYPE)))
    else $error("error LEDs do not show error type");
  ms_state_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (EXCEPTION_ERROR || !MODULE_INIT_DONE) |=>
      (MODULE_STATE_LED_RED == $past(EXCEPTION_ERROR) && !MODULE_STATE_LED_GREEN))
    else $error("module LED wrong for exception or init");
  ns_double_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (BUS_CFG_ERROR && phase_reg >= 5'h06) |=> (!NETWORK_OPERATION_LED_RED
                                              && !NETWORK_OPERATION_LED_GREEN))
    else $error("network LED lit in double flash pause");
  ns_run_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (!BUS_CFG_ERROR && BUS_ONLINE && DATA_EXCHANGE) |=> NETWORK_OPERATION_LED_GREEN)
    else $error("network LED not green in data exchange");
  flash_half_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (ms_next == MS_DIAG && phase_reg >= 5'h05 && phase_reg < 5'h0a) |=> !MODULE_STATE_LED_GREEN)
    else $error("module LED lit in flash off half");
  addr_range_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (STATION_ADDR >= 7'h01 && STATION_ADDR <= 7'h7e))
    else $error("station address out of range");
  addr_default_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    CFG_RESET |=> STATION_ADDR == 7'h01)
    else $error("address not back to default");

endmodule : fsi_status_led

/* testbench/fsi_master_model.sv */
// Bus master line model: drives a burst of edges onto the receive line
`timescale 1ns/100ps
module fsi_master_model
  import fsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [15:0] gap,
  output logic             rx_line,
  output logic             busy
);
  // Master maps three two-word slots each way; the first slot carries nothing
  localparam int unsigned MAP_WORDS = SLOT_COUNT * SLOT_WORDS;
  logic [15:0] tick;
  logic [4:0]  edges;
  // Line rests at mark between bursts, so the idle restart is exercised
  initial
  begin
    rx_line = 1'b1;
    busy    = 1'b0;
  end
  always @(posedge clk)
  begin
    if (start && !busy)
    begin
      busy  <= 1'b1;
      tick  <= 16'h0000;
      edges <= 5'h00;
    end
    else if (busy)
    begin
      tick <= tick + 16'h0001;
      if (tick == gap - 16'h0001)
      begin
        rx_line <= ~rx_line;
        tick    <= 16'h0000;
        edges   <= edges + 5'h01;
        busy    <= (edges != 5'h13);
      end
    end
  end
endmodule : fsi_master_model

/* testbench/test_fsi_status_led.sv */
// Self-checking bench for the status indicator block
`timescale 1ns/100ps
module test_fsi_status_led;
  import fsi_pkg::*;
  typedef struct {
    int         kind;
    logic [7:0] expv;
    logic [7:0] got;
  } fsi_note_type;
  logic               core_clk, reset_n, count_mode, stable_in, adc_error, dsp_error;
  logic signed [23:0] reading;
  logic [1:0]         error_type;
  logic               init_done, diag_pending, exc_error, online, data_xchg, cfg_error;
  logic               addr_write, cfg_reset, start, bus_rx, busy, rate_locked;
  logic [6:0]         addr_value, station_addr, led;
  logic [3:0]         line_rate;
  logic [15:0]        gap;
  int                 errors = 0;
  int                 check_count = 0;
  fsi_note_type       notes [$];
  event               result_ev;

  fsi_status_led #(.TICK_LEN(10), .IDLE_LEN(2000)) u_fsi_status_led (
    .CORE_CLK                    (core_clk),
    .RESET_N                     (reset_n),
    .COUNT_MODE                  (count_mode),
    .STABLE_IN                   (stable_in),
    .READING                     (reading),
    .ADC_ERROR                   (adc_error),
    .DSP_ERROR                   (dsp_error),
    .ERROR_TYPE                  (error_type),
    .MODULE_INIT_DONE            (init_done),
    .DIAG_PENDING                (diag_pending),
    .EXCEPTION_ERROR             (exc_error),
    .BUS_ONLINE                  (online),
    .DATA_EXCHANGE               (data_xchg),
    .BUS_CFG_ERROR               (cfg_error),
    .ADDR_WRITE                  (addr_write),
    .ADDR_VALUE                  (addr_value),
    .CFG_RESET                   (cfg_reset),
    .BUS_RX                      (bus_rx),
    .STABLE_LED                  (led[0]),
    .ZERO_LED                    (led[1]),
    .ERROR_LED                   (led[2]),
    .MODULE_STATE_LED_GREEN      (led[3]),
    .MODULE_STATE_LED_RED        (led[4]),
    .NETWORK_OPERATION_LED_GREEN (led[5]),
    .NETWORK_OPERATION_LED_RED   (led[6]),
    .STATION_ADDR                (station_addr),
    .LINE_RATE                   (line_rate),
    .LINE_RATE_LOCKED            (rate_locked)
  );
  fsi_master_model u_fsi_master_model (
    .clk     (core_clk),
    .start   (start),
    .gap     (gap),
    .rx_line (bus_rx),
    .busy    (busy)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Comparison and stimulus helpers
  // ----------------------------------------------------------------
  task automatic tally(input logic ok, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (!ok)
    begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : tally
  task automatic cmp_count(input logic [7:0] e, input logic [7:0] g);
    tally(g === e, e, g);
  endtask : cmp_count
  task automatic cmp_addr(input logic [6:0] e, input logic [6:0] g);
    tally(g === e, {1'b0, e}, {1'b0, g});
  endtask : cmp_addr
  task automatic cmp_rate(input logic [4:0] e, input logic [4:0] g);
    tally(g === e, {3'h0, e}, {3'h0, g});
  endtask : cmp_rate
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // One full 200-cycle pattern period, so lit counts do not depend on phase
  task automatic check_leds(input logic [7:0] e [7]);
    logic [7:0] cnt [7];
    cnt = '{default: 8'h00};
    repeat (3) @(posedge core_clk);
    repeat (200)
    begin
      @(negedge core_clk);
      for (int i = 0; i < 7; i++) cnt[i] += {7'h00, led[i]};
    end
    for (int i = 0; i < 7; i++) notes.push_back('{0, e[i], cnt[i]});
    -> result_ev;
  endtask : check_leds
  task automatic check_value(input int kind, input logic [7:0] e);
    @(negedge core_clk);
    notes.push_back('{kind, e, 8'h00});
    -> result_ev;
  endtask : check_value
  // Checks the result of the previous operation, taken at this edge
  task automatic addr_op(input logic wr, input logic [6:0] v, input logic rst,
                         input logic [6:0] e);
    @(posedge core_clk);
    addr_write <= wr;
    addr_value <= v;
    cfg_reset  <= rst;
    check_value(1, {1'b0, e});
  endtask : addr_op

  initial
  begin : monitor
    fsi_note_type n;
    forever
    begin
      @(result_ev);
      while (notes.size() > 0)
      begin
        n = notes.pop_front();
        if (n.kind == 0)
          cmp_count(n.expv, n.got);
        else if (n.kind == 1)
          cmp_addr(n.expv[6:0], station_addr);
        else
          cmp_rate(n.expv[4:0], {rate_locked, line_rate});
      end
    end
  end

  initial
  begin
    repeat (60000) @(posedge core_clk);
    errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin : main
    int          rv [6];
    int          idx;
    int          n;
    logic        st;
    logic        z;
    logic [15:0] gaps [3];
    logic [6:0]  av [8];
    logic [6:0]  ae [8];
    logic [2:0]  ms [4];
    logic [2:0]  ns [4];
    logic [7:0]  mg [4];
    logic [7:0]  mr [4];
    logic [7:0]  nr [4];
    {count_mode, stable_in, adc_error, dsp_error, error_type, reading} = '0;
    {init_done, diag_pending, exc_error, online, data_xchg, cfg_error} = '0;
    {addr_write, addr_value, cfg_reset, start} = '0;
    gap = 16'h0008;
    reset_n = 1'b0;
    void'($urandom(32'ha359));
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    count_mode <= 1'b1;
    check_leds('{8'haa, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("test count_mode done");
    rv = '{-4, -3, 0, 3, 4, 0};
    rv[5] = $urandom_range(15) - 8;
    for (int i = 0; i < 6; i++)
    begin
      st = 1'($urandom_range(1));
      z = (rv[i] < int'(ZERO_BAND)) && (rv[i] > -int'(ZERO_BAND));
      @(posedge core_clk);
      count_mode <= 1'b0;
      stable_in  <= st;
      reading    <= 24'(rv[i]);
      check_leds('{st ? 8'hc8 : 8'h00, z ? 8'hc8 : 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                   8'h00});
    end
    $display("test zero_band done");
    for (int k = 0; k < 8; k++)
    begin
      @(posedge core_clk);
      adc_error  <= k[2];
      dsp_error  <= ~k[2];
      error_type <= 2'(k);
      count_mode <= 1'($urandom_range(1));
      check_leds('{k[0] ? 8'hc8 : 8'h00, k[1] ? 8'hc8 : 8'h00, 8'hc8, 8'h00, 8'h00,
                   8'h00, 8'h00});
    end
    $display("test error_code done");
    ms = '{3'b000, 3'b100, 3'b110, 3'b001};
    ns = '{3'b000, 3'b110, 3'b100, 3'b001};
    mg = '{8'h00, 8'hc8, 8'h64, 8'h00};
    mr = '{8'h00, 8'h00, 8'h00, 8'hc8};
    nr = '{8'h00, 8'h00, 8'h00, 8'h28};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      {adc_error, dsp_error, count_mode, stable_in} <= 4'h0;
      reading <= 24'sh000100;
      {init_done, diag_pending, exc_error} <= ms[i];
      {online, data_xchg, cfg_error} <= ns[i];
      check_leds('{8'h00, 8'h00, 8'h00, mg[i], mr[i], mg[i], nr[i]});
    end
    $display("test state_leds done");
    av = '{7'h05, 7'h7e, 7'h00, 7'h7f, 7'h00, 7'h09, 7'h00, 7'h00};
    av[4] = 7'($urandom_range(126, 1));
    ae = '{ADDR_RESET, 7'h05, 7'h7e, 7'h7e, 7'h7e, 7'h00, ADDR_RESET, ADDR_RESET};
    ae[5] = av[4];
    for (int i = 0; i < 8; i++)
      addr_op(i < 6, av[i], i == 5, ae[i]);
    $display("test station_addr done");
    gaps = '{16'h0008, 16'h003c, 16'h0190};
    for (int g = 0; g < 3; g++)
    begin
      idx = 0;
      for (int j = 0; j < RATE_COUNT; j++)
        if (longint'(gaps[g]) * RATE_BPS[j] * 2 < 3 * longint'(CLK_HZ))
          idx = j;
      @(posedge core_clk);
      gap   <= gaps[g];
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      @(negedge core_clk);
      n = 0;
      while (busy !== 1'b0 && n < 20000)
      begin
        @(negedge core_clk);
        n++;
      end
      repeat (10) @(negedge core_clk);
      check_value(2, {3'h0, 1'b1, 4'(idx)});
      repeat (2100) @(posedge core_clk);
    end
    $display("test line_rate done");
    stop_test();
  end
endmodule : test_fsi_status_led
